// ===== pkg/plm_pkg.sv
// Shared constants for the primary-rate line maintenance block.
package plm_pkg;
   // Register byte offsets on the AXI4-Lite bus.
   localparam logic [7:0] PLM_OFS_CTRL = 8'h00;
   localparam logic [7:0] PLM_OFS_STATUS = 8'h04;
   localparam logic [7:0] PLM_OFS_INT_STATUS = 8'h08;
   localparam logic [7:0] PLM_OFS_INT_MASK = 8'h0c;
   localparam int PLM_ADDR_W = 8;

   // Control register fields.
   localparam int PLM_CTRL_ESF = 0;
   localparam int PLM_CTRL_LINE_EN = 1;
   localparam int PLM_CTRL_PAYLOAD_EN = 2;
   localparam int PLM_CTRL_PRM_EN = 3;
   localparam int PLM_CTRL_THR_LSB = 8;
   localparam int PLM_THR_W = 3;

   // Control reset values: extended superframe, both loop controls on, reports off.
   localparam logic PLM_RST_ESF = 1'b1;
   localparam logic PLM_RST_LINE_EN = 1'b1;
   localparam logic PLM_RST_PAYLOAD_EN = 1'b1;
   localparam logic PLM_RST_PRM_EN = 1'b0;
   localparam logic [2:0] PLM_RST_THR = 3'h0;
   localparam logic [2:0] PLM_THR_MAX = 3'h5;

   // Status register fields.
   localparam int PLM_ST_LINE_LOOP = 0;
   localparam int PLM_ST_PAYLOAD_LOOP = 1;
   localparam int PLM_ST_EER = 2;
   localparam int PLM_ST_LEVEL_LSB = 8;

   // Interrupt status and mask fields.
   localparam int PLM_INT_LINE_LOOP = 0;
   localparam int PLM_INT_PAYLOAD_LOOP = 1;
   localparam int PLM_INT_EER = 2;
   localparam int PLM_INT_PRM = 3;
   localparam int PLM_INT_W = 4;

   // AXI response codes.
   localparam logic [1:0] PLM_RESP_OKAY = 2'h0;
   localparam logic [1:0] PLM_RESP_SLVERR = 2'h2;

   // Error rate levels, index 0 is the highest rate.
   localparam int PLM_LEVELS = 6;
   localparam int PLM_CNT_W = 12;
   localparam int PLM_SEC_W = 12;
   localparam int PLM_SHORT_S = 10;
   localparam int PLM_MINUTE_S = 60;
   localparam int PLM_LONG_S = 3 * 15 * 60;
   localparam int PLM_PERIOD_S [PLM_LEVELS] =
      '{PLM_SHORT_S, PLM_MINUTE_S, PLM_MINUTE_S, PLM_MINUTE_S, PLM_LONG_S, PLM_LONG_S};
   localparam int PLM_LIMIT [PLM_LEVELS] = '{1535, 921, 92, 9, 41, 4};

   // Number of input pins passed through the synchroniser.
   localparam int PLM_SYNC_W = 7;
   localparam int PLM_IN_LSTART = 0;
   localparam int PLM_IN_LSTOP = 1;
   localparam int PLM_IN_PSTART = 2;
   localparam int PLM_IN_PSTOP = 3;
   localparam int PLM_IN_CRC = 4;
   localparam int PLM_IN_SEC = 5;
   localparam int PLM_IN_PERMIT = 6;
endpackage

// ===== rtl/plm_err_window.sv
// Error counter over fixed, back-to-back periods for one error rate level.
`timescale 1ns/10ps
module plm_err_window #(
   parameter int PERIOD_S = 10,
   parameter int LIMIT = 1535
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_enable,
   input wire logic i_tick,
   input wire logic i_err,
   output logic o_flag
);
   localparam logic [plm_pkg::PLM_SEC_W-1:0] LAST_SEC = plm_pkg::PLM_SEC_W'(PERIOD_S - 1);
   localparam logic [plm_pkg::PLM_CNT_W-1:0] LIMIT_C = plm_pkg::PLM_CNT_W'(LIMIT);
   localparam logic [plm_pkg::PLM_CNT_W-1:0] CNT_ONE = 12'h001;

   logic [plm_pkg::PLM_SEC_W-1:0] sec_cnt;
   logic [plm_pkg::PLM_CNT_W-1:0] err_cnt;
   logic [plm_pkg::PLM_CNT_W-1:0] next_err_cnt;
   logic period_end;

   // Counter saturates so that a long error burst cannot wrap below a limit.
   always_comb begin
      next_err_cnt = err_cnt;
      if (i_err && (err_cnt != '1)) begin
         next_err_cnt = err_cnt + CNT_ONE;
      end
   end

   assign period_end = i_tick && (sec_cnt == LAST_SEC);

   // RL14: consecutive periods.
   always_ff @(posedge i_clk) begin
      if (i_rst || !i_enable) begin
         sec_cnt <= '0;
      end else if (i_ce && i_tick) begin
         sec_cnt <= period_end ? '0 : sec_cnt + 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst || !i_enable) begin
         err_cnt <= '0;
      end else if (i_ce) begin
         err_cnt <= period_end ? '0 : next_err_cnt;
      end
   end

   // RL14: flag at period end.
   always_ff @(posedge i_clk) begin
      if (i_rst || !i_enable) begin
         o_flag <= 1'b0;
      end else if (i_ce && period_end) begin
         o_flag <= (next_err_cnt > LIMIT_C);
      end
   end
endmodule

// ===== rtl/plm_top.sv
// Line maintenance: framing select, network loopbacks, reports and error rate.
// Functional notes
// RL1: Selected framing, D4 or extended superframe, applies both directions; ESF after reset.
// RL2: Line loop control enabled by default; start command enters if permitted, stop leaves.
// RL3: With line loop control disabled, start and stop commands are ignored.
// RL4: ESF and payload control enabled: start enters payload loop if permitted, stop ends.
// RL5: With payload loop control disabled, payload start and stop commands are ignored.
// RL6: Reporting on and ESF: send a performance report every second; off by default.
// RL7: In ESF, excessive error rate judged from CRC6 counts; six levels, first after reset.
// RL8: Highest level: declare above 1535 errors per 10 s, clear below 1536.
// RL9: Second level: above 921 per 60 s or higher condition; clear below 922.
// RL10: Third level: above 92 per 60 s or higher condition; clear below 93.
// RL11: Fourth level: above 9 per 60 s or higher condition; clear below 10.
// RL12: Fifth level: above 41 over three 15 minute intervals or higher; clear below 42.
// RL13: Lowest level: above 4 over three 15 minute intervals or higher; clear below 5.
// RL14: Each threshold uses back-to-back periods; flag updated at each period end.
`timescale 1ns/10ps
module plm_top (
   input wire logic I_MCLK,
   input wire logic I_SYS_RST,
   input wire logic I_CE,
   input wire logic I_AXI_AWVALID,
   output logic O_AXI_AWREADY,
   input wire logic [7:0] I_AXI_AWADDR,
   input wire logic I_AXI_WVALID,
   output logic O_AXI_WREADY,
   input wire logic [31:0] I_AXI_WDATA,
   input wire logic [3:0] I_AXI_WSTRB,
   output logic O_AXI_BVALID,
   input wire logic I_AXI_BREADY,
   output logic [1:0] O_AXI_BRESP,
   input wire logic I_AXI_ARVALID,
   output logic O_AXI_ARREADY,
   input wire logic [7:0] I_AXI_ARADDR,
   output logic O_AXI_RVALID,
   input wire logic I_AXI_RREADY,
   output logic [31:0] O_AXI_RDATA,
   output logic [1:0] O_AXI_RRESP,
   input wire logic I_LINE_LOOP_START_COMMAND,
   input wire logic I_LINE_LOOP_STOP_COMMAND,
   input wire logic I_PAYLOAD_LOOP_START_COMMAND,
   input wire logic I_PAYLOAD_LOOP_STOP_COMMAND,
   input wire logic I_CRC6_ERROR,
   input wire logic I_ONE_SECOND,
   input wire logic I_LOOP_PERMIT,
   output logic O_ESF_MODE,
   output logic O_LINE_LOOPBACK,
   output logic O_PAYLOAD_LOOPBACK,
   output logic O_EXCESSIVE_ERROR_RATE,
   output logic O_PERFORMANCE_REPORT_MESSAGE,
   output logic [11:0] O_REPORT_ERROR_COUNT,
   output logic O_IRQ
);
   localparam logic [11:0] CNT_ONE = 12'h001;
   logic esf, line_en, payload_en, prm_en;
   logic [plm_pkg::PLM_THR_W-1:0] thr_sel;
   logic [plm_pkg::PLM_SYNC_W-1:0] sync_a, sync_b, sync_c, rise;
   logic lstart, lstop, pstart, pstop, crc_err, sec_tick, permit;
   logic line_loopback, payload_loopback, next_line_loopback, next_payload_loopback;
   logic [plm_pkg::PLM_LEVELS-1:0] level_flag;
   logic excessive_error_rate, next_eer, prm_fire;
   logic [11:0] sec_err_cnt;
   logic [plm_pkg::PLM_INT_W-1:0] int_status, int_mask, int_set, int_clr;
   logic aw_held, w_held, do_write, ar_hs, rd_ok, wr_ok;
   logic [plm_pkg::PLM_ADDR_W-1:0] aw_addr;
   logic [31:0] w_data, rd_mux;
   logic [3:0] w_strb;

   // Pins come from the line side, so two flops precede any logic.
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         sync_a <= '0;
         sync_b <= '0;
         sync_c <= '0;
      end else if (I_CE) begin
         sync_a <= {I_LOOP_PERMIT, I_ONE_SECOND, I_CRC6_ERROR, I_PAYLOAD_LOOP_STOP_COMMAND,
                    I_PAYLOAD_LOOP_START_COMMAND, I_LINE_LOOP_STOP_COMMAND,
                    I_LINE_LOOP_START_COMMAND};
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end

   // Strobes may last several clocks, so only their rising edge counts.
   genvar gi;
   generate
      for (gi = 0; gi < plm_pkg::PLM_SYNC_W; gi++) begin : g_rise
         assign rise[gi] = I_CE && sync_b[gi] && !sync_c[gi];
      end
   endgenerate

   assign lstart = rise[plm_pkg::PLM_IN_LSTART];
   assign lstop = rise[plm_pkg::PLM_IN_LSTOP];
   assign pstart = rise[plm_pkg::PLM_IN_PSTART];
   assign pstop = rise[plm_pkg::PLM_IN_PSTOP];
   assign crc_err = rise[plm_pkg::PLM_IN_CRC];
   assign sec_tick = rise[plm_pkg::PLM_IN_SEC];
   assign permit = sync_b[plm_pkg::PLM_IN_PERMIT];

   // Line loopback; stop wins when both commands land together.
   always_comb begin
      next_line_loopback = line_loopback;
      // RL2: network line loop control.
      if (line_en) begin
         if (lstop) begin
            next_line_loopback = 1'b0;
         end else if (lstart && permit && !payload_loopback) begin
            next_line_loopback = 1'b1;
         end
      end
      // RL3: disabled control ignores commands, the line loop simply holds.
   end

   // Payload loopback needs ESF; a change to D4 drops it because the loop lives in ESF.
   always_comb begin
      next_payload_loopback = payload_loopback;
      // RL5: disabled control ignores commands.
      if (!esf) begin
         next_payload_loopback = 1'b0;
      // RL4: network payload loop control.
      end else if (payload_en) begin
         if (pstop) begin
            next_payload_loopback = 1'b0;
         end else if (pstart && permit && !next_line_loopback) begin
            next_payload_loopback = 1'b1;
         end
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         line_loopback <= 1'b0;
         payload_loopback <= 1'b0;
      end else if (I_CE) begin
         line_loopback <= next_line_loopback;
         payload_loopback <= next_payload_loopback;
      end
   end

   // RL8 RL9 RL10 RL11 RL12 RL13: one window per level.
   generate
      for (gi = 0; gi < plm_pkg::PLM_LEVELS; gi++) begin : g_level
         plm_err_window #(
            .PERIOD_S(plm_pkg::PLM_PERIOD_S[gi]),
            .LIMIT(plm_pkg::PLM_LIMIT[gi])
         ) u_window (
            .i_clk(I_MCLK),
            .i_rst(I_SYS_RST),
            .i_ce(I_CE),
            .i_enable(esf),
            .i_tick(sec_tick),
            .i_err(crc_err),
            .o_flag(level_flag[gi])
         );
      end
   endgenerate

   // RL7: ESF only, selected level or any higher one.
   always_comb begin
      next_eer = 1'b0;
      for (int k = 0; k < plm_pkg::PLM_LEVELS; k++) begin
         if (esf && (k <= int'(thr_sel)) && level_flag[k]) begin
            next_eer = 1'b1;
         end
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         excessive_error_rate <= 1'b0;
      end else if (I_CE) begin
         excessive_error_rate <= next_eer;
      end
   end

   // RL6: one report per second.
   assign prm_fire = sec_tick && esf && prm_en;

   // The report carries the CRC6 errors seen in the second that just ended.
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         sec_err_cnt <= '0;
         O_PERFORMANCE_REPORT_MESSAGE <= 1'b0;
         O_REPORT_ERROR_COUNT <= '0;
      end else if (I_CE) begin
         O_PERFORMANCE_REPORT_MESSAGE <= prm_fire;
         if (sec_tick) begin
            sec_err_cnt <= '0;
         end else if (crc_err && (sec_err_cnt != '1)) begin
            sec_err_cnt <= sec_err_cnt + CNT_ONE;
         end
         if (prm_fire) begin
            O_REPORT_ERROR_COUNT <= sec_err_cnt + (crc_err ? CNT_ONE : 12'h000);
         end
      end
   end

   // Interrupt events; a set in the clearing cycle survives.
   always_comb begin
      int_set = '0;
      int_set[plm_pkg::PLM_INT_LINE_LOOP] = next_line_loopback != line_loopback;
      int_set[plm_pkg::PLM_INT_PAYLOAD_LOOP] = next_payload_loopback != payload_loopback;
      int_set[plm_pkg::PLM_INT_EER] = next_eer != excessive_error_rate;
      int_set[plm_pkg::PLM_INT_PRM] = prm_fire;
      int_clr = '0;
      if (do_write && wr_ok && (aw_addr == plm_pkg::PLM_OFS_INT_STATUS) && w_strb[0]) begin
         int_clr = w_data[plm_pkg::PLM_INT_W-1:0];
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         int_status <= '0;
      end else if (I_CE) begin
         int_status <= (int_status & ~int_clr) | int_set;
      end
   end

   // Bus write address and data are taken independently.
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         O_AXI_AWREADY <= 1'b0;
         O_AXI_WREADY <= 1'b0;
      end else if (I_CE) begin
         if (I_AXI_AWVALID && O_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= I_AXI_AWADDR;
            O_AXI_AWREADY <= 1'b0;
         end else begin
            if (do_write) begin
               aw_held <= 1'b0;
            end
            O_AXI_AWREADY <= !aw_held && !O_AXI_BVALID;
         end
         if (I_AXI_WVALID && O_AXI_WREADY) begin
            w_held <= 1'b1;
            w_data <= I_AXI_WDATA;
            w_strb <= I_AXI_WSTRB;
            O_AXI_WREADY <= 1'b0;
         end else begin
            if (do_write) begin
               w_held <= 1'b0;
            end
            O_AXI_WREADY <= !w_held && !O_AXI_BVALID;
         end
      end
   end

   assign do_write = aw_held && w_held && !O_AXI_BVALID;
   assign wr_ok = (aw_addr == plm_pkg::PLM_OFS_CTRL) || (aw_addr == plm_pkg::PLM_OFS_STATUS)
      || (aw_addr == plm_pkg::PLM_OFS_INT_STATUS) || (aw_addr == plm_pkg::PLM_OFS_INT_MASK);

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         O_AXI_BVALID <= 1'b0;
         O_AXI_BRESP <= plm_pkg::PLM_RESP_OKAY;
      end else if (I_CE) begin
         if (do_write) begin
            O_AXI_BVALID <= 1'b1;
            O_AXI_BRESP <= wr_ok ? plm_pkg::PLM_RESP_OKAY : plm_pkg::PLM_RESP_SLVERR;
         end else if (I_AXI_BREADY) begin
            O_AXI_BVALID <= 1'b0;
         end
      end
   end

   // Configuration writes; an out-of-range threshold leaves the old one in place.
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         // RL1: ESF after reset.
         esf <= plm_pkg::PLM_RST_ESF;
         line_en <= plm_pkg::PLM_RST_LINE_EN;
         payload_en <= plm_pkg::PLM_RST_PAYLOAD_EN;
         prm_en <= plm_pkg::PLM_RST_PRM_EN;
         // RL7: first level after reset.
         thr_sel <= plm_pkg::PLM_RST_THR;
         int_mask <= '0;
      end else if (I_CE && do_write) begin
         if ((aw_addr == plm_pkg::PLM_OFS_CTRL) && w_strb[0]) begin
            esf <= w_data[plm_pkg::PLM_CTRL_ESF];
            line_en <= w_data[plm_pkg::PLM_CTRL_LINE_EN];
            payload_en <= w_data[plm_pkg::PLM_CTRL_PAYLOAD_EN];
            prm_en <= w_data[plm_pkg::PLM_CTRL_PRM_EN];
         end
         if ((aw_addr == plm_pkg::PLM_OFS_CTRL) && w_strb[1]
             && (w_data[plm_pkg::PLM_CTRL_THR_LSB +: plm_pkg::PLM_THR_W]
                 <= plm_pkg::PLM_THR_MAX)) begin
            thr_sel <= w_data[plm_pkg::PLM_CTRL_THR_LSB +: plm_pkg::PLM_THR_W];
         end
         if ((aw_addr == plm_pkg::PLM_OFS_INT_MASK) && w_strb[0]) begin
            int_mask <= w_data[plm_pkg::PLM_INT_W-1:0];
         end
      end
   end

   always_comb begin
      rd_mux = '0;
      rd_ok = 1'b1;
      unique case (I_AXI_ARADDR)
         plm_pkg::PLM_OFS_CTRL: begin
            rd_mux[plm_pkg::PLM_CTRL_ESF] = esf;
            rd_mux[plm_pkg::PLM_CTRL_LINE_EN] = line_en;
            rd_mux[plm_pkg::PLM_CTRL_PAYLOAD_EN] = payload_en;
            rd_mux[plm_pkg::PLM_CTRL_PRM_EN] = prm_en;
            rd_mux[plm_pkg::PLM_CTRL_THR_LSB +: plm_pkg::PLM_THR_W] = thr_sel;
         end
         plm_pkg::PLM_OFS_STATUS: begin
            rd_mux[plm_pkg::PLM_ST_LINE_LOOP] = line_loopback;
            rd_mux[plm_pkg::PLM_ST_PAYLOAD_LOOP] = payload_loopback;
            rd_mux[plm_pkg::PLM_ST_EER] = excessive_error_rate;
            rd_mux[plm_pkg::PLM_ST_LEVEL_LSB +: plm_pkg::PLM_LEVELS] = level_flag;
         end
         plm_pkg::PLM_OFS_INT_STATUS: begin
            rd_mux[plm_pkg::PLM_INT_W-1:0] = int_status;
         end
         plm_pkg::PLM_OFS_INT_MASK: begin
            rd_mux[plm_pkg::PLM_INT_W-1:0] = int_mask;
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
   end
   assign ar_hs = I_AXI_ARVALID && O_AXI_ARREADY;

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         O_AXI_ARREADY <= 1'b0;
         O_AXI_RVALID <= 1'b0;
         O_AXI_RDATA <= '0;
         O_AXI_RRESP <= plm_pkg::PLM_RESP_OKAY;
      end else if (I_CE) begin
         if (ar_hs) begin
            O_AXI_ARREADY <= 1'b0;
            O_AXI_RVALID <= 1'b1;
            O_AXI_RDATA <= rd_mux;
            O_AXI_RRESP <= rd_ok ? plm_pkg::PLM_RESP_OKAY : plm_pkg::PLM_RESP_SLVERR;
         end else begin
            if (O_AXI_RVALID && I_AXI_RREADY) begin
               O_AXI_RVALID <= 1'b0;
            end
            O_AXI_ARREADY <= !O_AXI_RVALID;
         end
      end
   end

   // Outputs; framing applies to both directions of the line.
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         O_ESF_MODE <= plm_pkg::PLM_RST_ESF;
         O_LINE_LOOPBACK <= 1'b0;
         O_PAYLOAD_LOOPBACK <= 1'b0;
         O_EXCESSIVE_ERROR_RATE <= 1'b0;
         O_IRQ <= 1'b0;
      end else if (I_CE) begin
         // RL1: framing to line.
         O_ESF_MODE <= esf;
         O_LINE_LOOPBACK <= next_line_loopback;
         O_PAYLOAD_LOOPBACK <= next_payload_loopback;
         O_EXCESSIVE_ERROR_RATE <= next_eer;
         O_IRQ <= |(((int_status & ~int_clr) | int_set) & int_mask);
      end
   end
endmodule

// ===== tb/plm_props.sv
// Concurrent checks on the line maintenance block's top-level ports.
`timescale 1ns/10ps
module plm_props (
   input wire logic I_MCLK,
   input wire logic I_SYS_RST,
   input wire logic I_AXI_AWVALID,
   input wire logic O_AXI_AWREADY,
   input wire logic I_AXI_WVALID,
   input wire logic O_AXI_WREADY,
   input wire logic O_AXI_BVALID,
   input wire logic I_AXI_ARVALID,
   input wire logic O_AXI_ARREADY,
   input wire logic O_AXI_RVALID,
   input wire logic I_AXI_RREADY,
   input wire logic [31:0] O_AXI_RDATA,
   input wire logic I_LINE_LOOP_START_COMMAND,
   input wire logic I_ONE_SECOND,
   input wire logic O_ESF_MODE,
   input wire logic O_LINE_LOOPBACK,
   input wire logic O_PAYLOAD_LOOPBACK,
   input wire logic O_EXCESSIVE_ERROR_RATE,
   input wire logic O_PERFORMANCE_REPORT_MESSAGE
);
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (I_SYS_RST);
   a_read_answer: assert property (I_AXI_ARVALID && O_AXI_ARREADY |=>
      O_AXI_RVALID && !O_AXI_ARREADY) else $error("read answer not one cycle after address");
   a_write_answer: assert property (I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID &&
      O_AXI_WREADY |=> !O_AXI_BVALID ##1 O_AXI_BVALID) else $error("write answer late");
   a_rdata_holds: assert property (O_AXI_RVALID && !I_AXI_RREADY |=>
      O_AXI_RVALID && $stable(O_AXI_RDATA)) else $error("read data dropped early");
   a_loops_exclusive: assert property (
      !(O_LINE_LOOPBACK && O_PAYLOAD_LOOPBACK)) else $error("both loopbacks active");
   a_payload_needs_esf: assert property (
      $fell(O_ESF_MODE) |-> ##[0:2] !O_PAYLOAD_LOOPBACK) else $error("payload loop in D4");
   a_report_single: assert property (
      O_PERFORMANCE_REPORT_MESSAGE |=> !O_PERFORMANCE_REPORT_MESSAGE [*3])
      else $error("report pulse too long");
   a_report_in_esf: assert property (
      O_PERFORMANCE_REPORT_MESSAGE |-> O_ESF_MODE) else $error("report sent in D4");
   a_report_after_tick: assert property (
      O_PERFORMANCE_REPORT_MESSAGE |-> $past(I_ONE_SECOND, 3) || $past(I_ONE_SECOND, 4)
      || $past(I_ONE_SECOND, 5)) else $error("report without second tick");
   a_loop_after_start: assert property (
      $rose(O_LINE_LOOPBACK) |-> $past(I_LINE_LOOP_START_COMMAND, 3) ||
      $past(I_LINE_LOOP_START_COMMAND, 4) || $past(I_LINE_LOOP_START_COMMAND, 5))
      else $error("line loop without start command");
   a_eer_in_esf: assert property (
      $rose(O_EXCESSIVE_ERROR_RATE) |-> O_ESF_MODE) else $error("error rate flag in D4");
endmodule

// ===== tb/plm_net_model.sv
// Network side model: loop commands, CRC6 error events and second ticks.
`timescale 1ns/10ps
module plm_net_model (
   input wire logic i_clk,
   output logic [6:0] o_pins
);
   initial o_pins = 7'h00;
   // Two clocks high and two low keep every edge visible through the synchroniser.
   task automatic pulse(input int idx, input int n);
      @(posedge i_clk);
      repeat (n) begin
         o_pins[idx] <= 1'h1;
         repeat (2) @(posedge i_clk);
         o_pins[idx] <= 1'h0;
         repeat (2) @(posedge i_clk);
      end
   endtask
   task automatic permit(input logic v);
      @(posedge i_clk);
      o_pins[plm_pkg::PLM_IN_PERMIT] <= v;
   endtask
endmodule

// ===== tb/plm_bench.sv
// Register, loopback, report and error rate tests for the line maintenance block.
`timescale 1ns/10ps
module plm_bench;
   logic mclk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0;
   logic rready = 1'h0, awr, wrd, bv, arr, rv, esf, ll, pl, excessive_error_rate, rpt, irq;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rdd, got;
   logic [1:0] br, rr, rsp;
   logic [11:0] rcnt;
   logic [6:0] pins;
   int error_cnt = 0, samples_checked = 0, rpt_seen = 0;
   logic [11:0] step [11] = '{12'h500, 12'h701, 12'h511, 12'h710, 12'h320, 12'h722,
      12'h332, 12'h730, 12'h722, 12'h610, 12'h620};
   always #20 mclk = ~mclk;
   always @(posedge mclk) if (rpt === 1'h1) rpt_seen <= rpt_seen + 1;
   plm_top u_plm_top (.I_MCLK(mclk), .I_SYS_RST(rst), .I_CE(1'h1),
      .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr), .I_AXI_AWADDR(awa), .I_AXI_WVALID(wv),
      .O_AXI_WREADY(wrd), .I_AXI_WDATA(wd), .I_AXI_WSTRB(4'hf), .O_AXI_BVALID(bv),
      .I_AXI_BREADY(bready), .O_AXI_BRESP(br), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr),
      .I_AXI_ARADDR(ara), .O_AXI_RVALID(rv), .I_AXI_RREADY(rready), .O_AXI_RDATA(rdd),
      .O_AXI_RRESP(rr), .I_LINE_LOOP_START_COMMAND(pins[0]),
      .I_LINE_LOOP_STOP_COMMAND(pins[1]), .I_PAYLOAD_LOOP_START_COMMAND(pins[2]),
      .I_PAYLOAD_LOOP_STOP_COMMAND(pins[3]), .I_CRC6_ERROR(pins[4]),
      .I_ONE_SECOND(pins[5]), .I_LOOP_PERMIT(pins[6]), .O_ESF_MODE(esf),
      .O_LINE_LOOPBACK(ll), .O_PAYLOAD_LOOPBACK(pl), .O_EXCESSIVE_ERROR_RATE(excessive_error_rate),
      .O_PERFORMANCE_REPORT_MESSAGE(rpt), .O_REPORT_ERROR_COUNT(rcnt), .O_IRQ(irq));
   plm_net_model u_plm_net_model (.i_clk(mclk), .o_pins(pins));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      samples_checked++;
      if (exp !== seen) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta = 1'h0, tw = 1'h0;
      @(posedge mclk);
      awa <= a;
      wd <= d;
      {awv, wv, bready} <= 3'h7;
      do begin
         @(posedge mclk);
         ta |= awr;
         tw |= wrd;
         awv <= !ta;
         wv <= !tw;
      end while (!(ta && tw));
      do @(posedge mclk); while (bv !== 1'h1);
      r = br;
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      ara <= a;
      arv <= 1'h1;
      do @(posedge mclk); while (arr !== 1'h1);
      arv <= 1'h0;
      do @(posedge mclk); while (rv !== 1'h1);
      rready <= 1'h1;
      @(posedge mclk);
      d = rdd;
      r = rr;
      rready <= 1'h0;
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      wr(a, d, rsp);
      chk("write resp", 32'h0, {30'h0, rsp});
   endtask
   task automatic ev(input int idx);
      u_plm_net_model.pulse(idx, 1);
      repeat (4) @(posedge mclk);
   endtask
   task automatic run_period(input int l, input int n);
      for (int t = 0; t < plm_pkg::PLM_PERIOD_S[l]; t++) begin
         if (l < 4 && t == 0)
            u_plm_net_model.pulse(plm_pkg::PLM_IN_CRC, n);
         // Slow levels get one error a minute so no faster level trips on the way.
         if (l >= 4 && t % 60 == 0 && t / 60 < n)
            u_plm_net_model.pulse(plm_pkg::PLM_IN_CRC, 1);
         u_plm_net_model.pulse(plm_pkg::PLM_IN_SEC, 1);
      end
      repeat (6) @(posedge mclk);
   endtask
   // The two slowest levels dominate; the full run takes about 78000 clocks.
   initial begin
      repeat (100000) @(posedge mclk);
      error_cnt++;
      complete_run;
   end
   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'h0;
      repeat (2) @(posedge mclk);
      chk("esf pin", 32'h1, {31'h0, esf});
      rd(plm_pkg::PLM_OFS_CTRL, got, rsp);
      chk("ctrl reset", 32'h7, got);
      rd(8'h40, got, rsp);
      chk("unmapped resp", {30'h0, plm_pkg::PLM_RESP_SLVERR}, {30'h0, rsp});
      $display("Test reset values done");
      u_plm_net_model.permit(1'h1);
      w(plm_pkg::PLM_OFS_INT_MASK, 32'h0);
      ev(plm_pkg::PLM_IN_LSTART);
      chk("line loop on", 32'h1, {31'h0, ll});
      chk("masked irq", 32'h0, {31'h0, irq});
      w(plm_pkg::PLM_OFS_INT_MASK, 32'hf);
      repeat (2) @(posedge mclk);
      chk("irq", 32'h1, {31'h0, irq});
      w(plm_pkg::PLM_OFS_INT_STATUS, 32'h1);
      repeat (2) @(posedge mclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      ev(plm_pkg::PLM_IN_PSTART);
      chk("payload refused", 32'h0, {31'h0, pl});
      ev(plm_pkg::PLM_IN_LSTOP);
      $display("Test interrupt done");
      for (int i = 0; i < 11; i++) begin
         w(plm_pkg::PLM_OFS_CTRL, {28'h0, step[i][11:8]});
         ev(int'(step[i][7:4]));
         chk("esf", {31'h0, step[i][8]}, {31'h0, esf});
         chk("loops", {30'h0, step[i][1:0]}, {30'h0, pl, ll});
      end
      u_plm_net_model.permit(1'h0);
      w(plm_pkg::PLM_OFS_CTRL, 32'h7);
      ev(plm_pkg::PLM_IN_LSTART);
      chk("no permit", 32'h0, {31'h0, ll});
      $display("Test loopbacks done");
      w(plm_pkg::PLM_OFS_CTRL, 32'he);
      u_plm_net_model.pulse(plm_pkg::PLM_IN_SEC, 2);
      repeat (4) @(posedge mclk);
      chk("reports in d4", 32'h0, rpt_seen);
      w(plm_pkg::PLM_OFS_CTRL, 32'hf);
      u_plm_net_model.pulse(plm_pkg::PLM_IN_SEC, 1);
      u_plm_net_model.pulse(plm_pkg::PLM_IN_CRC, 3);
      u_plm_net_model.pulse(plm_pkg::PLM_IN_SEC, 1);
      repeat (4) @(posedge mclk);
      chk("reports", 32'h2, rpt_seen);
      chk("report count", 32'h3, {20'h0, rcnt});
      $display("Test reports done");
      for (int l = 0; l < plm_pkg::PLM_LEVELS; l++) begin
         w(plm_pkg::PLM_OFS_CTRL, {21'h0, 3'(l), 8'h06});
         w(plm_pkg::PLM_OFS_CTRL, {21'h0, 3'(l), 8'h07});
         for (int k = 1; k >= 0; k--) begin
            run_period(l, plm_pkg::PLM_LIMIT[l] + k);
            chk("eer", k, {31'h0, excessive_error_rate});
            if (l == 0 && k == 1) begin
               w(plm_pkg::PLM_OFS_CTRL, 32'h507);
               repeat (3) @(posedge mclk);
               chk("eer lowest level", 32'h1, {31'h0, excessive_error_rate});
               w(plm_pkg::PLM_OFS_CTRL, 32'h007);
            end
         end
      end
      $display("Test error rate done");
      complete_run;
   end
endmodule
bind plm_top plm_props u_plm_props (.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST),
   .I_AXI_AWVALID(I_AXI_AWVALID), .O_AXI_AWREADY(O_AXI_AWREADY),
   .I_AXI_WVALID(I_AXI_WVALID), .O_AXI_WREADY(O_AXI_WREADY), .O_AXI_BVALID(O_AXI_BVALID),
   .I_AXI_ARVALID(I_AXI_ARVALID), .O_AXI_ARREADY(O_AXI_ARREADY),
   .O_AXI_RVALID(O_AXI_RVALID), .I_AXI_RREADY(I_AXI_RREADY), .O_AXI_RDATA(O_AXI_RDATA),
   .I_LINE_LOOP_START_COMMAND(I_LINE_LOOP_START_COMMAND), .I_ONE_SECOND(I_ONE_SECOND),
   .O_ESF_MODE(O_ESF_MODE), .O_LINE_LOOPBACK(O_LINE_LOOPBACK),
   .O_PAYLOAD_LOOPBACK(O_PAYLOAD_LOOPBACK), .O_EXCESSIVE_ERROR_RATE(O_EXCESSIVE_ERROR_RATE),
   .O_PERFORMANCE_REPORT_MESSAGE(O_PERFORMANCE_REPORT_MESSAGE));
